// *** common/itfm_pkg.sv ***
// Package for the input terminal function mapper: register map, reset values,
// function codes and the command carrier.
// Assumes a 32-bit classic Wishbone register bus and one clock domain.
package itfm_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int          NUM_TERM  = 6;
    localparam int          NUM_CODES = 84;
    localparam int          ADDR_W    = 8;
    localparam int          DATA_W    = 32;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0]  OFS_FAST_TYPE  = 8'h00;
    localparam logic [7:0]  OFS_FUNC_BASE  = 8'h04;
    localparam logic [7:0]  OFS_FUNC_LAST  = 8'h18;
    localparam logic [7:0]  OFS_POLARITY   = 8'h1c;
    localparam logic [7:0]  OFS_CONTROL    = 8'h20;
    localparam logic [7:0]  OFS_STATUS     = 8'h24;
    localparam logic [7:0]  OFS_COMMAND    = 8'h28;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int          CTL_TENSION_BIT = 0;
    localparam int          CTL_FIRE_BIT    = 1;
    localparam int          STS_MASTER_BIT  = 8;
    localparam int          STS_SLAVE_BIT   = 9;
    localparam int          FAST_A_IDX      = 4;
    localparam int          FAST_B_IDX      = 5;
    localparam logic [3:0]  FAST_DIGITAL    = 4'h1;
    localparam logic [7:0]  RST_FAST_TYPE   = 8'h00;
    localparam logic [7:0]  RST_FUNC_ONE    = 8'h01;
    localparam logic [7:0]  RST_FUNC_TWO    = 8'h04;
    localparam logic [7:0]  RST_FUNC_THREE  = 8'h07;
    localparam logic [7:0]  RST_FUNC_OTHER  = 8'h00;
    localparam logic [5:0]  RST_POLARITY    = 6'h00;
    localparam logic [1:0]  RST_CONTROL     = 2'h0;

    // ------------------------------------------------------------------
    // Function codes
    // ------------------------------------------------------------------
    localparam int C_FWD_RUN = 1,  C_REV_RUN = 2,  C_THREE_WIRE = 3, C_FWD_JOG = 4;
    localparam int C_REV_JOG = 5,  C_COAST = 6,    C_FAULT_RST = 7,  C_PAUSE = 8;
    localparam int C_EXT_FAULT = 9, C_UP = 10,     C_DOWN = 11,      C_UD_CLR = 12;
    localparam int C_SWAP_AB = 13, C_SWAP_CA = 14, C_SWAP_CB = 15,   C_STEP0 = 16;
    localparam int C_STEP_PAUSE = 20, C_ACCDEC = 21;
    localparam int C_MASTER = 71,  C_SLAVE = 72,   C_ROLL_RST = 73,  C_WIND = 74;
    localparam int C_PREDRIVE = 75, C_CALC_INH = 76, C_ALARM_CLR = 77, C_BRAKE = 78;
    localparam int C_FEED_INT = 79, C_PRESET0 = 80, C_PRESET1 = 81;
    localparam int C_FIRE = 82,    C_PID2 = 83;

    // ------------------------------------------------------------------
    // Command carrier, 32 bits, readable at OFS_COMMAND
    // ------------------------------------------------------------------
    typedef struct packed {
        logic       pid_group2;
        logic       fire_ctrl;
        logic [1:0] roll_preset;
        logic       feed_interrupt;
        logic       manual_brake;
        logic       alarm_clear;
        logic       roll_calc_inhibit;
        logic       pre_drive;
        logic       wind_toggle;
        logic       roll_reset;
        logic       accdec_sel;
        logic       step_pause;
        logic [3:0] step_sel;
        logic       swap_comb_b;
        logic       swap_comb_a;
        logic       swap_a_b;
        logic       updown_clear;
        logic       freq_down;
        logic       freq_up;
        logic       ext_fault;
        logic       run_pause;
        logic       fault_reset;
        logic       coast_stop;
        logic       rev_jog;
        logic       fwd_jog;
        logic       three_wire;
        logic       rev_run;
        logic       fwd_run;
    } itfm_cmd_t;

endpackage

// *** rtl/itfm_decode.sv ***
// One terminal's function decoder: turns a function code and an active level
// into a one-hot hit vector over the mapped codes.
// Assumes codes at or above NCODES are reserved and map to nothing.
module itfm_decode #(
    parameter int NCODES = 84
) (
    input  wire logic [7:0]        code,
    input  wire logic              active,
    output logic      [NCODES-1:0] hits
);

    // ------------------------------------------------------------------
    // One comparator per code; code 0 never hits
    // ------------------------------------------------------------------
    for (genvar i = 0; i < NCODES; i++) begin : g_code
        if (i == 0) begin : g_none
            assign hits[i] = 1'b0;
        end else begin : g_hit
            assign hits[i] = active && (code == 8'(i));
        end
    end

endmodule

// *** rtl/itfm_mapper.sv ***
// Input terminal function mapper: six input terminals, each with its own
// function selector, decoded into one set of internal drive commands.
// Assumes a classic Wishbone master on ref_clk, asynchronous terminal pins,
// and drive_stopped coming from logic on the same clock.
import itfm_pkg::*;

// Behaviour
// RULE1: Fast input type from ones/tens digits
// RULE2: Six function selectors with defaults 1,4,7,0
// RULE3: Decode codes 1 to 8 run controls
// RULE4: Codes 9-12 fault, up, down, clear
// RULE5: Codes 13-15 setpoint source swaps
// RULE6: Codes 16-21 multi-step bits, pause, ramps
// RULE7: Code 71 selects master only when stopped
// RULE8: Code 72 selects slave only when stopped
// RULE9: Code 73 resets roll if tension enabled
// RULE10: Codes 74-78 act only with tension enabled
// RULE11: Code 79 forces feed interrupt with tension
// RULE12: Codes 80,81 form roll preset selector
// RULE13: Code 82 fires control only in fire mode
// RULE14: Code 83 picks second tension PID group
// RULE15: Polarity mask inverts terminal levels, resets zero
// RULE16: Reserved codes 84-95 produce no command
module itfm_mapper #(
    parameter int NTERM = NUM_TERM
) (
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    // Wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADDR_W-1:0] wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [DATA_W-1:0] wb_dat_i,
    output logic      [DATA_W-1:0] wb_dat_o,
    output logic                   wb_ack_o,
    // Terminal pins and drive state
    input  wire logic [NTERM-1:0]  terminal_in,
    input  wire logic              drive_stopped,
    // Decoded commands
    output itfm_cmd_t              cmd,
    output logic                   master_sel,
    output logic                   slave_sel,
    output logic                   fast_input_a_pulse,
    output logic                   fast_input_b_pulse
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // A type digit selects the plain digital role only when it reads one
    function automatic logic fast_is_digital(input logic [3:0] digit);
        return digit == FAST_DIGITAL;
    endfunction

    // Reset value of each function selector
    function automatic logic [7:0] func_reset(input int idx);
        case (idx)
            0:       return RST_FUNC_ONE;
            1:       return RST_FUNC_TWO;
            2:       return RST_FUNC_THREE;
            default: return RST_FUNC_OTHER;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]           fast_type;
    logic [7:0]           func_sel [NTERM];
    logic [5:0]           polarity;
    logic                 tension_en;
    logic                 fire_active;
    logic [NTERM-1:0]     term_sync;
    logic [NTERM-1:0]     term_level;
    logic [NTERM-1:0]     digital_en;
    logic [NTERM-1:0]     term_active;
    logic [NUM_CODES-1:0] term_hits [NTERM];
    logic [NUM_CODES-1:0] hit;
    itfm_cmd_t            next_cmd;
    logic                 bus_req;
    logic                 bus_wr;
    logic [7:0]           bus_ofs;
    logic                 func_wr;
    logic [2:0]           func_idx;
    logic [DATA_W-1:0]    next_rdata;

    // ------------------------------------------------------------------
    // Bus request decode
    // ------------------------------------------------------------------

    // A request is taken once, in the cycle before its acknowledge
    assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign bus_wr   = bus_req && wb_we_i && wb_sel_i[0];
    assign bus_ofs  = {wb_adr_i[7:2], 2'b00};
    assign func_wr  = bus_wr && (bus_ofs >= OFS_FUNC_BASE) && (bus_ofs <= OFS_FUNC_LAST);
    assign func_idx = 3'((bus_ofs - OFS_FUNC_BASE) >> 2);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    // Fast input type setting, ones digit for input A, tens for B
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_type <= RST_FAST_TYPE;
        end else if (bus_wr && bus_ofs == OFS_FAST_TYPE) begin
            fast_type <= wb_dat_i[7:0]; // see RULE1
        end
    end

    // Per-terminal function selectors, addressed by index
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < NTERM; i++) begin
                func_sel[i] <= func_reset(i); // see RULE2
            end
        end else if (func_wr) begin
            func_sel[func_idx] <= wb_dat_i[7:0]; // see RULE2
        end
    end

    // Polarity mask, six bits, upper bits dropped
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            polarity <= RST_POLARITY; // see RULE15
        end else if (bus_wr && bus_ofs == OFS_POLARITY) begin
            polarity <= wb_dat_i[5:0];
        end
    end

    // Feature enables: tension control and fire mode
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            tension_en  <= RST_CONTROL[CTL_TENSION_BIT];
            fire_active <= RST_CONTROL[CTL_FIRE_BIT];
        end else if (bus_wr && bus_ofs == OFS_CONTROL) begin
            tension_en  <= wb_dat_i[CTL_TENSION_BIT];
            fire_active <= wb_dat_i[CTL_FIRE_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Terminal conditioning
    // ------------------------------------------------------------------

    // Pins cross into the clock domain first
    itfm_sync #(
        .WIDTH (NTERM)
    ) u_sync (
        .ref_clk   (ref_clk),
        .rst_b     (rst_b),
        .pin_in    (terminal_in),
        .level_out (term_sync)
    );

    // Each set mask bit inverts the active level of its terminal
    assign term_level = term_sync ^ polarity[NTERM-1:0]; // see RULE15

    // Fast inputs only take part as terminals in digital role
    always_comb begin
        digital_en             = '1;
        digital_en[FAST_A_IDX] = fast_is_digital(fast_type[3:0]); // see RULE1
        digital_en[FAST_B_IDX] = fast_is_digital(fast_type[7:4]); // see RULE1
    end

    assign term_active = term_level & digital_en;

    // ------------------------------------------------------------------
    // Function decode
    // ------------------------------------------------------------------

    // One decoder per terminal; reserved codes fall outside the vector
    for (genvar t = 0; t < NTERM; t++) begin : g_term
        itfm_decode #(
            .NCODES (NUM_CODES)
        ) u_decode (
            .code   (func_sel[t]),
            .active (term_active[t]),
            .hits   (term_hits[t])   // see RULE16
        );
    end

    // Several terminals may share one code; any of them asserts it
    always_comb begin
        hit = '0;
        for (int t = 0; t < NTERM; t++) begin
            hit = hit | term_hits[t];
        end
    end

    // ------------------------------------------------------------------
    // Command assembly
    // ------------------------------------------------------------------

    // Run and stop controls
    always_comb begin
        next_cmd              = '0;
        next_cmd.fwd_run      = hit[C_FWD_RUN];    // see RULE3
        next_cmd.rev_run      = hit[C_REV_RUN];    // see RULE3
        next_cmd.three_wire   = hit[C_THREE_WIRE]; // see RULE3
        next_cmd.fwd_jog      = hit[C_FWD_JOG];    // see RULE3
        next_cmd.rev_jog      = hit[C_REV_JOG];    // see RULE3
        next_cmd.coast_stop   = hit[C_COAST];      // see RULE3
        next_cmd.fault_reset  = hit[C_FAULT_RST];  // see RULE3
        next_cmd.run_pause    = hit[C_PAUSE];      // see RULE3
        // Fault and frequency trim
        next_cmd.ext_fault    = hit[C_EXT_FAULT];  // see RULE4
        next_cmd.freq_up      = hit[C_UP];         // see RULE4
        next_cmd.freq_down    = hit[C_DOWN];       // see RULE4
        next_cmd.updown_clear = hit[C_UD_CLR];     // see RULE4
        // Setpoint source swaps
        next_cmd.swap_a_b     = hit[C_SWAP_AB];    // see RULE5
        next_cmd.swap_comb_a  = hit[C_SWAP_CA];    // see RULE5
        next_cmd.swap_comb_b  = hit[C_SWAP_CB];    // see RULE5
        // Multi-step speed, bit 0 from the lowest code
        next_cmd.step_sel     = hit[C_STEP0 +: 4]; // see RULE6
        next_cmd.step_pause   = hit[C_STEP_PAUSE]; // see RULE6
        next_cmd.accdec_sel   = hit[C_ACCDEC];     // see RULE6
        // Tension control commands exist only with the feature enabled
        if (tension_en) begin
            next_cmd.roll_reset        = hit[C_ROLL_RST];  // see RULE9
            next_cmd.wind_toggle       = hit[C_WIND];      // see RULE10
            next_cmd.pre_drive         = hit[C_PREDRIVE];  // see RULE10
            next_cmd.roll_calc_inhibit = hit[C_CALC_INH];  // see RULE10
            next_cmd.alarm_clear       = hit[C_ALARM_CLR]; // see RULE10
            next_cmd.manual_brake      = hit[C_BRAKE];     // see RULE10
            next_cmd.feed_interrupt    = hit[C_FEED_INT];  // see RULE11
            next_cmd.roll_preset       = {hit[C_PRESET1], hit[C_PRESET0]}; // see RULE12
            next_cmd.pid_group2        = hit[C_PID2];      // see RULE14
        end
        // Fire mode control passes only while fire mode is active
        next_cmd.fire_ctrl = fire_active && hit[C_FIRE]; // see RULE13
    end

    // Registered command outputs
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd <= '0;
        end else begin
            cmd <= next_cmd;
        end
    end

    // ------------------------------------------------------------------
    // Master and slave selection
    // ------------------------------------------------------------------

    // Role changes only while stopped; held while running; master first
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            master_sel <= 1'b0;
            slave_sel  <= 1'b0;
        end else if (drive_stopped) begin
            if (hit[C_MASTER]) begin
                master_sel <= 1'b1; // see RULE7
                slave_sel  <= 1'b0;
            end else if (hit[C_SLAVE]) begin
                master_sel <= 1'b0; // see RULE8
                slave_sel  <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Fast input pulse paths
    // ------------------------------------------------------------------

    // In pulse role the synchronised level goes to the pulse counter side
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            fast_input_a_pulse <= 1'b0;
            fast_input_b_pulse <= 1'b0;
        end else begin
            fast_input_a_pulse <= !digital_en[FAST_A_IDX] && term_sync[FAST_A_IDX]; // see RULE1
            fast_input_b_pulse <= !digital_en[FAST_B_IDX] && term_sync[FAST_B_IDX]; // see RULE1
        end
    end

    // ------------------------------------------------------------------
    // Register read back
    // ------------------------------------------------------------------

    // Read mux; unmapped offsets read as zero
    always_comb begin
        next_rdata = '0;
        case (bus_ofs)
            OFS_FAST_TYPE: begin
                next_rdata[7:0] = fast_type;
            end
            OFS_POLARITY: begin
                next_rdata[5:0] = polarity;
            end
            OFS_CONTROL: begin
                next_rdata[CTL_TENSION_BIT] = tension_en;
                next_rdata[CTL_FIRE_BIT]    = fire_active;
            end
            OFS_STATUS: begin
                next_rdata[NTERM-1:0]     = term_active;
                next_rdata[STS_MASTER_BIT] = master_sel;
                next_rdata[STS_SLAVE_BIT]  = slave_sel;
            end
            OFS_COMMAND: begin
                next_rdata = cmd;
            end
            default: begin
                if (bus_ofs >= OFS_FUNC_BASE && bus_ofs <= OFS_FUNC_LAST) begin
                    next_rdata[7:0] = func_sel[func_idx];
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Wishbone answer
    // ------------------------------------------------------------------

    // Acknowledge one cycle after the request, drop it the cycle after
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
        end
    end

    // Read data is captured with the acknowledge and held until the next
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_dat_o <= '0;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
        end
    end

endmodule

// *** rtl/itfm_sync.sv ***
// Two-stage synchroniser for a bundle of asynchronous pin levels.
// Assumes each bit is an independent level; no bus coherency is given.
module itfm_sync #(
    parameter int WIDTH = 6
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    logic [WIDTH-1:0] stage_one;

    // ------------------------------------------------------------------
    // Two flip-flops; only the second stage reads the first
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_one <= '0;
            level_out <= '0;
        end else begin
            stage_one <= pin_in;
            level_out <= stage_one;
        end
    end

endmodule

// *** test/itfm_checker.sv ***
// Checker for the terminal mapper: bus handshake, role latching, gating.
// Assumes it is bound to itfm_mapper and sees only its ports.
module itfm_checker
    import itfm_pkg::*;
#(
    parameter int NTERM = NUM_TERM
) (
    input wire logic              ref_clk,
    input wire logic              rst_b,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    input wire logic [DATA_W-1:0] wb_dat_o,
    input wire logic              wb_ack_o,
    input wire logic [NTERM-1:0]  terminal_in,
    input wire logic              drive_stopped,
    input wire itfm_cmd_t         cmd,
    input wire logic              master_sel,
    input wire logic              slave_sel,
    input wire logic              fast_input_a_pulse,
    input wire logic              fast_input_b_pulse
);
    logic tension_q, fire_q, dig_a_q, dig_b_q;
    logic take_wr;
    // ----------------------------------------
    // Shadow of control and input type
    // ----------------------------------------
    assign take_wr = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0];
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            {tension_q, fire_q, dig_a_q, dig_b_q} <= 4'h0;
        end else if (take_wr && wb_adr_i[7:2] == OFS_CONTROL[7:2]) begin
            {fire_q, tension_q} <= wb_dat_i[1:0];
        end else if (take_wr && wb_adr_i[7:2] == OFS_FAST_TYPE[7:2]) begin
            dig_a_q <= wb_dat_i[3:0] == FAST_DIGITAL;
            dig_b_q <= wb_dat_i[7:4] == FAST_DIGITAL;
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    ack_answer_a: assert property (s_req |=> s_ack) else $error("ack late or long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
    role_excl_a: assert property (!(master_sel && slave_sel)) else $error("both roles");
    role_hold_a: assert property (!drive_stopped |=> $stable(master_sel) && $stable(slave_sel))
        else $error("role moved while running");
    fire_gate_a: assert property (!$past(fire_q) |-> !cmd.fire_ctrl) else $error("fire outside mode");
    tension_gate_a: assert property (!$past(tension_q) |-> !cmd.pid_group2 && cmd[29:21] == 9'h000)
        else $error("tension command while off");
    fast_a_role_a: assert property (dig_a_q && $past(dig_a_q) |-> !fast_input_a_pulse)
        else $error("pulse on digital input a");
    fast_b_role_a: assert property (dig_b_q && $past(dig_b_q) |-> !fast_input_b_pulse)
        else $error("pulse on digital input b");
endmodule

bind itfm_mapper itfm_checker #(.NTERM(NTERM)) i_itfm_checker (.ref_clk(ref_clk), .rst_b(rst_b),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .terminal_in(terminal_in),
    .drive_stopped(drive_stopped), .cmd(cmd), .master_sel(master_sel), .slave_sel(slave_sel),
    .fast_input_a_pulse(fast_input_a_pulse), .fast_input_b_pulse(fast_input_b_pulse));

// *** test/itfm_pins.sv ***
// Model of the switches wired to the six input terminals.
// Assumes the bench sets the wanted levels just after a rising edge.
module itfm_pins (
    input  wire logic       ref_clk,
    input  wire logic [5:0] want,
    output logic      [5:0] terminal_in
);
    timeunit 1ns;
    timeprecision 1ps;
    initial terminal_in = 6'h00;
    // Contacts settle one edge after being thrown
    always @(posedge ref_clk) terminal_in <= want;
endmodule

// *** test/test_input_terminal_function_mapper.sv ***
// Testbench for the terminal mapper: register defaults, every code, gating,
// polarity, pulse role, master/slave roles and a reset in mid-run.
// Assumes itfm_pkg, itfm_mapper, the checker and the pin model are compiled.
module test_input_terminal_function_mapper;
    import itfm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed { logic [7:0] code; logic [31:0] exp; } itfm_row_t;
    localparam logic [7:0] RV [10] = '{8'h00, 8'h01, 8'h04, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic        ref_clk, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, drive_stopped;
    logic        master_sel, slave_sel, fast_input_a_pulse, fast_input_b_pulse;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdata, mask;
    logic [5:0]  want, terminal_in;
    itfm_cmd_t   cmd;
    itfm_row_t   rows [97];
    int          errors, cmp_count, i, t, p, n;
    itfm_mapper i_itfm_mapper (.ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .terminal_in(terminal_in), .drive_stopped(drive_stopped), .cmd(cmd),
        .master_sel(master_sel), .slave_sel(slave_sel), .fast_input_a_pulse(fast_input_a_pulse),
        .fast_input_b_pulse(fast_input_b_pulse));
    itfm_pins i_itfm_pins (.ref_clk(ref_clk), .want(want), .terminal_in(terminal_in));
    // ----------------------------------------
    // Clock, report and bus tasks
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic single cycle, held until ack is sampled
    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, 24'h0, d};
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rdata = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 50) begin
            errors++;
            end_of_test();
        end
    endtask
    task automatic settle();
        repeat (6) @(posedge ref_clk);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, drive_stopped} = 5'h00;
        {wb_adr_i, wb_sel_i, wb_dat_i, want, errors, cmp_count} = '0;
        wb_sel_i = 4'hf;
        for (i = 0; i < 97; i++) begin
            rows[i].code = (i == 96) ? 8'hff : 8'(i);
            rows[i].exp = (i >= 1 && i <= 21) ? 32'h1 << (i - 1) : (i >= 73 && i <= 83) ? 32'h1 << (i - 52) : 32'h0;
        end
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        for (i = 0; i < 11; i++) begin
            bus(1'b0, (i == 10) ? 8'h40 : 8'(4 * i), 8'h00);
            chk(rdata, {24'h0, (i == 10) ? 8'h00 : RV[i]});
        end
        bus(1'b1, OFS_FAST_TYPE, 8'h11);
        for (p = 0; p < 2; p++) begin
            bus(1'b1, OFS_CONTROL, p ? 8'h00 : 8'h03);
            mask = p ? 32'h001fffff : 32'hffffffff;
            for (i = 0; i < 97; i++) begin
                t = rows[i].code % 6;
                bus(1'b1, OFS_FUNC_BASE + 8'(4 * t), rows[i].code);
                want <= 6'h01 << t;
                settle();
                chk(cmd, rows[i].exp & mask);
                want <= 6'h00;
                settle();
                chk(cmd, 32'h0);
            end
        end
        // Inverted terminal one reads active with its pin low
        bus(1'b1, OFS_FUNC_BASE, 8'h01);
        bus(1'b1, OFS_POLARITY, 8'h01);
        settle();
        chk(cmd, 32'h1);
        bus(1'b1, OFS_POLARITY, 8'h00);
        // Fast input a as pulse, b digital
        bus(1'b1, OFS_FUNC_BASE + 8'h10, 8'h01);
        bus(1'b1, OFS_FAST_TYPE, 8'h10);
        want <= 6'h30;
        settle();
        chk({30'h0, fast_input_b_pulse, fast_input_a_pulse}, 32'h1);
        chk(cmd, 32'h0);
        // Roles: refused while running, held, master wins a tie
        want <= 6'h00;
        bus(1'b1, OFS_FUNC_BASE, 8'd71);
        bus(1'b1, OFS_FUNC_BASE + 8'h04, 8'd72);
        for (i = 0; i < 5; i++) begin
            want <= (i == 2) ? 6'h02 : (i == 4) ? 6'h03 : 6'h01;
            drive_stopped <= (i == 1 || i == 2 || i == 4);
            settle();
            chk({30'h0, slave_sel, master_sel}, (i == 0) ? 32'h0 : (i == 1 || i == 4) ? 32'h1 : 32'h2);
        end
        // Reset in mid-run clears cmd and both roles and restores the first function selector default
        rst_b <= 1'b0;
        @(posedge ref_clk);
        @(posedge ref_clk);
        chk(cmd | {30'h0, slave_sel, master_sel}, 32'h0);
        want <= 6'h00;
        rst_b <= 1'b1;
        bus(1'b0, OFS_FUNC_BASE, 8'h00);
        chk(rdata, 32'h1);
        end_of_test();
    end
endmodule
